// >>> rtl/bac_defines.svh
// constants of the data-format conversion datapath
`ifndef BAC_DEFINES_SVH
`define BAC_DEFINES_SVH

// ascii character codes, held in 16-bit data registers
`define BAC_ASCII_ZERO 16'h0030
`define BAC_ASCII_NINE 16'h0039
`define BAC_ASCII_A 16'h0041
`define BAC_ASCII_F 16'h0046
`define BAC_ALPHA_BASE 16'h0037
`define BAC_ALPHA_ADJ 4'h9

// value limits
`define BAC_DIGIT_MAX 4'h9
`define BAC_BCD_SRC_MAX 16'h270f
`define BAC_DEC_RESULT_MAX 17'h0ffff
`define BAC_BCD_ADJ_LIMIT 4'h4
`define BAC_BCD_ADJ 4'h3

// digit-count limits
`define BAC_CNT_MIN 16'h0001
`define BAC_HEX_CNT_MAX 16'h0004
`define BAC_DEC_CNT_MAX 16'h0005

// decimal weights
`define BAC_W10 16'h000a
`define BAC_W100 16'h0064
`define BAC_W1000 16'h03e8
`define BAC_TEN17 17'h0000a

`endif

// >>> rtl/bac_pkg.sv
// types of the data-format conversion datapath
package bac_pkg;

  // conversion operations
  typedef enum logic [2:0] {
    BAC_BCD_TO_BINARY_OP = 3'b000,
    BAC_BINARY_TO_BCD_OP = 3'b001,
    BAC_BINARY_TO_ASCII_HEX_OP = 3'b010,
    BAC_ASCII_HEX_TO_BINARY_OP = 3'b011,
    BAC_BINARY_TO_ASCII_DECIMAL_OP = 3'b100,
    BAC_ASCII_DECIMAL_TO_BINARY_OP = 3'b101
  } bac_op_e;

  // kind of a source or digit-count operand
  typedef enum logic [1:0] {
    BAC_SRC_BITS = 2'b00,
    BAC_SRC_WORD = 2'b01,
    BAC_SRC_TIMER = 2'b10
  } bac_src_kind_e;

  // kind of a destination operand
  typedef enum logic [1:0] {
    BAC_DST_BITS = 2'b00,
    BAC_DST_WORD = 2'b01,
    BAC_DST_TIMER = 2'b10,
    BAC_DST_SPECIAL = 2'b11
  } bac_dst_kind_e;

  // five consecutive character registers, index 0 is the first one
  typedef logic [4:0][15:0] bac_chars_t;

endpackage

// >>> rtl/bac_bin_to_bcd.sv
// binary to five-digit bcd converter, combinational shift-and-add-three
`timescale 1ns/100ps
`include "bac_defines.svh"
module bac_bin_to_bcd (
  // binary in
  input wire logic [15:0] bin,
  // five bcd digits out, lowest digit in bits 3:0
  output logic [19:0] bcd
);

  // sixteen shift steps, each digit corrected before the shift
  always_comb begin
    logic [35:0] work;
    work = {20'h00000, bin};
    for (int s = 0; s < 16; s++) begin
      for (int d = 0; d < 5; d++) begin
        if (work[16 + 4 * d +: 4] > `BAC_BCD_ADJ_LIMIT) begin
          work[16 + 4 * d +: 4] = work[16 + 4 * d +: 4] + `BAC_BCD_ADJ;
        end
      end
      work = {work[34:0], 1'b0};
    end
    bcd = work[35:16];
  end

endmodule // bac_bin_to_bcd

// >>> rtl/bac_converter.sv
// data-format conversion datapath: bcd, binary and ascii conversions
`timescale 1ns/100ps
`include "bac_defines.svh"
// Contract
// - bcd source becomes sixteen-bit binary destination
// - bcd nibbles above nine are invalid
// - invalid source or count sets error flag, indicator
// - timer/counter destination receives result as preset
// - timer/counter source reads its current value
// - bit-point operand uses sixteen points
// - word operand uses one element
// - binary to hex characters, lowest digits taken
// - hex digit count must be one to four
// - hex characters combine into one binary word
// - hex characters only digits or A to F
// - ascii-to-binary checks characters and count
// - binary to bcd then decimal characters
// - decimal digit count must be one to five
// - decimal characters to bcd then binary
// - decimal characters only digits zero to nine
// - conversion repeats every scan while condition true
// - special relays refused as destination
// - decimal output fills up to five registers
// - binary-to-bcd source above 9999 is an error
module bac_converter (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // instruction request
  input wire logic op_req,
  input wire bac_pkg::bac_op_e op_code,
  input wire logic cond_in,
  // source operand
  input wire bac_pkg::bac_src_kind_e src_kind,
  input wire logic [15:0] src_data,
  input wire logic [15:0] src_tc_current,
  input wire bac_pkg::bac_chars_t src_chars,
  // digit-count operand
  input wire bac_pkg::bac_src_kind_e cnt_kind,
  input wire logic [15:0] cnt_data,
  input wire logic [15:0] cnt_tc_current,
  // destination operand
  input wire bac_pkg::bac_dst_kind_e dst_kind,
  // result
  output logic done,
  output logic dst_wr,
  output logic preset_wr,
  output logic [15:0] dst_data,
  output logic [4:0] char_wr,
  output bac_pkg::bac_chars_t char_data,
  // error reporting
  input wire logic err_clr,
  output logic exec_error_flag,
  output logic err_led
);
  import bac_pkg::*;

  // ascii hex character to {valid, nibble}
  function automatic logic [4:0] hex_nib(input logic [15:0] c);
    if (c >= `BAC_ASCII_ZERO && c <= `BAC_ASCII_NINE) begin
      return {1'b1, c[3:0]};
    end else if (c >= `BAC_ASCII_A && c <= `BAC_ASCII_F) begin
      return {1'b1, c[3:0] + `BAC_ALPHA_ADJ};
    end
    return 5'h00;
  endfunction

  // ascii decimal character to {valid, digit}; letters are not digits here
  function automatic logic [4:0] dec_nib(input logic [15:0] c);
    if (c >= `BAC_ASCII_ZERO && c <= `BAC_ASCII_NINE) begin
      return {1'b1, c[3:0]};
    end
    return 5'h00;
  endfunction

  // nibble to ascii character
  function automatic logic [15:0] to_char(input logic [3:0] n);
    if (n <= `BAC_DIGIT_MAX) begin
      return `BAC_ASCII_ZERO | {12'h000, n};
    end
    return `BAC_ALPHA_BASE + {12'h000, n};
  endfunction

  // pick digit k out of five packed digits
  function automatic logic [3:0] pick(input logic [19:0] d, input logic [2:0] k);
    logic [19:0] sh;
    sh = d >> {k, 2'b00};
    return sh[3:0];
  endfunction

  // operand selection: a timer or counter gives its current value, bit groups and
  // words both arrive as one 16-bit word from the operand fetch
  wire [15:0] src_sel = (src_kind == BAC_SRC_TIMER) ? src_tc_current : src_data;
  wire [15:0] cnt_sel = (cnt_kind == BAC_SRC_TIMER) ? cnt_tc_current : cnt_data;

  // digit-count range checks
  wire hex_cnt_ok = (cnt_sel >= `BAC_CNT_MIN) && (cnt_sel <= `BAC_HEX_CNT_MAX);
  wire dec_cnt_ok = (cnt_sel >= `BAC_CNT_MIN) && (cnt_sel <= `BAC_DEC_CNT_MAX);

  // per character and per digit decode
  logic [4:0] in_cnt;
  logic [4:0] hex_ok;
  logic [4:0] dec_ok;
  logic [4:0][3:0] hex_val;
  logic [4:0][3:0] dec_val;
  logic [3:0] bcd_bad;
  for (genvar i = 0; i < 5; i++) begin : g_char
    assign in_cnt[i] = cnt_sel > 16'(i);
    assign hex_ok[i] = hex_nib(src_chars[i])[4];
    assign hex_val[i] = hex_nib(src_chars[i])[3:0];
    assign dec_ok[i] = dec_nib(src_chars[i])[4];
    assign dec_val[i] = dec_nib(src_chars[i])[3:0];
  end
  for (genvar i = 0; i < 4; i++) begin : g_bcd
    assign bcd_bad[i] = src_sel[4 * i +: 4] > `BAC_DIGIT_MAX;
  end

  // characters outside the count are never looked at
  wire hex_chars_ok = &(~in_cnt | hex_ok);
  wire dec_chars_ok = &(~in_cnt | dec_ok);

  // character strings to binary, first register most significant
  logic [15:0] hex_acc;
  logic [16:0] dec_acc;
  always_comb begin
    hex_acc = 16'h0000;
    dec_acc = 17'h00000;
    for (int i = 0; i < 5; i++) begin
      if (in_cnt[i]) begin
        hex_acc = {hex_acc[11:0], hex_val[i]};
        dec_acc = 17'(dec_acc * `BAC_TEN17 + {13'h0000, dec_val[i]});
      end
    end
  end

  // bcd word to binary by decimal weights
  wire [15:0] bcd_bin = 16'({12'h000, src_sel[15:12]} * `BAC_W1000 + {12'h000, src_sel[11:8]} * `BAC_W100
                          + {12'h000, src_sel[7:4]} * `BAC_W10 + {12'h000, src_sel[3:0]});

  // binary to bcd, shared by the binary-to-bcd and binary-to-decimal-character operations
  logic [19:0] src_bcd;
  bac_bin_to_bcd u_bin_to_bcd (
    .bin(src_sel),
    .bcd(src_bcd)
  );

  // digit strings for the character outputs; the hex form has no fifth digit
  wire [19:0] hex_digits = {4'h0, src_sel};
  wire is_dec_out = (op_code == BAC_BINARY_TO_ASCII_DECIMAL_OP);
  wire [19:0] out_digits = is_dec_out ? src_bcd : hex_digits;

  // register j gets digit n-1-j, so the lowest digit lands in the last register
  bac_chars_t next_char_data;
  for (genvar j = 0; j < 5; j++) begin : g_out
    wire [2:0] idx = 3'(cnt_sel[2:0] - 3'(j + 1));
    assign next_char_data[j] = to_char(pick(out_digits, idx));
  end

  // error decision per operation
  wire dst_special = (dst_kind == BAC_DST_SPECIAL);
  wire dst_not_reg = (dst_kind != BAC_DST_WORD);
  logic next_err;
  logic [15:0] next_bin;
  logic next_chars;
  always_comb begin
    next_err = 1'b0;
    next_bin = 16'h0000;
    next_chars = 1'b0;
    case (op_code)
      BAC_BCD_TO_BINARY_OP: begin
        next_err = (|bcd_bad) || dst_special;
        next_bin = bcd_bin;
      end
      BAC_BINARY_TO_BCD_OP: begin
        next_err = (src_sel > `BAC_BCD_SRC_MAX) || dst_special;
        next_bin = src_bcd[15:0];
      end
      BAC_BINARY_TO_ASCII_HEX_OP: begin
        next_err = !hex_cnt_ok || dst_not_reg;
        next_chars = 1'b1;
      end
      BAC_ASCII_HEX_TO_BINARY_OP: begin
        next_err = !hex_cnt_ok || !hex_chars_ok || dst_special;
        next_bin = hex_acc;
      end
      BAC_BINARY_TO_ASCII_DECIMAL_OP: begin
        next_err = !dec_cnt_ok || dst_not_reg;
        next_chars = 1'b1;
      end
      BAC_ASCII_DECIMAL_TO_BINARY_OP: begin
        // five digits can exceed one word; such a result is refused, not cut
        next_err = !dec_cnt_ok || !dec_chars_ok || dst_special || (dec_acc > `BAC_DEC_RESULT_MAX);
        next_bin = dec_acc[15:0];
      end
      default: begin
        next_err = 1'b1;
      end
    endcase
  end

  // write strobes; an erring conversion writes nothing
  wire run = op_req && cond_in;
  wire good = run && !next_err;
  wire next_dst_wr = good && !next_chars && (dst_kind != BAC_DST_TIMER);
  wire next_preset_wr = good && !next_chars && (dst_kind == BAC_DST_TIMER);
  wire [4:0] next_char_wr = (good && next_chars) ? in_cnt : 5'h00;
  wire raise_err = run && next_err;
  // a new error wins over a clear in the same cycle so no event is lost
  wire next_flag = raise_err || (exec_error_flag && !err_clr);

  // result stage: one cycle from request to strobes, so the result is written
  // before the scan engine issues its next instruction
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      done <= 1'b0;
      dst_wr <= 1'b0;
      preset_wr <= 1'b0;
      char_wr <= 5'h00;
    end else begin
      done <= op_req;
      dst_wr <= next_dst_wr;
      preset_wr <= next_preset_wr;
      char_wr <= next_char_wr;
    end
  end

  // data is loaded only on a good conversion and otherwise held
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dst_data <= 16'h0000;
      char_data <= '0;
    end else if (good) begin
      dst_data <= next_bin;
      char_data <= next_char_data;
    end
  end

  // sticky error flag and its indicator
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      exec_error_flag <= 1'b0;
      err_led <= 1'b0;
    end else begin
      exec_error_flag <= next_flag;
      err_led <= next_flag;
    end
  end

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_accept;
    op_req && cond_in;
  endsequence

  sequence s_quiet;
    !dst_wr && !preset_wr && (char_wr == 5'h00);
  endsequence

  // error flag and its indicator both up
  sequence s_flagged;
    exec_error_flag && err_led;
  endsequence

  AST_DONE_NEXT: assert property (op_req |=> done ##1 !done || $past(op_req))
    else $error("done did not follow the request by one cycle");
  AST_BCD_BAD_NIBBLE: assert property (s_accept ##0 (op_code == BAC_BCD_TO_BINARY_OP && (|bcd_bad))
      |=> exec_error_flag and s_quiet)
    else $error("invalid bcd nibble was converted");
  AST_HEX_COUNT: assert property (s_accept ##0 (op_code == BAC_BINARY_TO_ASCII_HEX_OP && !hex_cnt_ok)
      |=> exec_error_flag && err_led && (char_wr == 5'h00))
    else $error("bad hex digit count accepted");
  AST_DEC_COUNT: assert property (s_accept ##0 (op_code == BAC_BINARY_TO_ASCII_DECIMAL_OP && !dec_cnt_ok)
      |=> exec_error_flag and s_quiet)
    else $error("bad decimal digit count accepted");
  AST_TIMER_PRESET: assert property (s_accept ##0 (!next_err && !next_chars && dst_kind == BAC_DST_TIMER)
      |=> preset_wr && !dst_wr && dst_data == $past(next_bin))
    else $error("timer destination not written as preset");
  AST_SPECIAL_DEST: assert property (s_accept ##0 (op_code == BAC_BCD_TO_BINARY_OP && dst_special)
      |=> exec_error_flag && !dst_wr)
    else $error("special relay accepted as destination");
  AST_NO_COND: assert property (op_req && !cond_in |=> s_quiet)
    else $error("conversion ran with condition false");
  AST_HOLD_ON_ERR: assert property (s_accept ##0 next_err |=> ($stable(dst_data) && $stable(char_data)) and s_quiet)
    else $error("destination changed on an erring conversion");
  AST_FLAG_STICKY: assert property (exec_error_flag && !err_clr |=> exec_error_flag [*1] ##0 err_led)
    else $error("error flag dropped without a clear");
  AST_BCD_RANGE: assert property (s_accept ##0 (op_code == BAC_BINARY_TO_BCD_OP
      && src_sel > `BAC_BCD_SRC_MAX) |=> exec_error_flag && !dst_wr && !preset_wr)
    else $error("binary-to-bcd source above range converted");
  AST_HEX_CHAR_A: assert property (s_accept ##0 (op_code == BAC_BINARY_TO_ASCII_HEX_OP
      && cnt_sel == `BAC_CNT_MIN && src_sel[3:0] == 4'ha && !next_err)
      |=> char_wr == 5'h01 && char_data[0] == `BAC_ASCII_A)
    else $error("hex digit ten not encoded as letter A");
  // a clear with no new error in the same cycle must drop flag and lamp
  AST_CLEAR_WORKS: assert property (err_clr && !raise_err |=> !exec_error_flag && !err_led)
    else $error("error flag survived a clear");
  AST_HEX_CHAR_BAD: assert property (s_accept ##0 (op_code == BAC_ASCII_HEX_TO_BINARY_OP && !hex_chars_ok)
      |=> s_flagged and s_quiet)
    else $error("invalid hex character converted");
  AST_DEC_CHAR_BAD: assert property (s_accept ##0 (op_code == BAC_ASCII_DECIMAL_TO_BINARY_OP && !dec_chars_ok)
      |=> s_flagged and s_quiet)
    else $error("invalid decimal character converted");
  AST_DEC_FIVE_REGS: assert property (s_accept ##0 (is_dec_out && cnt_sel == `BAC_DEC_CNT_MAX && !next_err)
      |=> char_wr == 5'h1f && !dst_wr && !preset_wr)
    else $error("five decimal digits did not fill five registers");

endmodule // bac_converter

// >>> tb/bac_converter_tb.sv
// self-checking testbench of the data-format conversion datapath
`timescale 1ns/100ps
module bac_converter_tb;
  import bac_pkg::*;
  localparam bac_src_kind_e sw = BAC_SRC_WORD;
  localparam bac_src_kind_e st = BAC_SRC_TIMER;
  localparam bac_src_kind_e sb = BAC_SRC_BITS;
  localparam bac_dst_kind_e dw = BAC_DST_WORD;
  localparam bac_dst_kind_e dt = BAC_DST_TIMER;
  localparam bac_dst_kind_e db = BAC_DST_BITS;
  localparam bac_dst_kind_e dsp = BAC_DST_SPECIAL;
  localparam bac_op_e op_bcd = BAC_BCD_TO_BINARY_OP;
  localparam bac_op_e op_tobcd = BAC_BINARY_TO_BCD_OP;
  localparam bac_op_e op_hex = BAC_BINARY_TO_ASCII_HEX_OP;
  localparam bac_op_e op_hexin = BAC_ASCII_HEX_TO_BINARY_OP;
  localparam bac_op_e op_dec = BAC_BINARY_TO_ASCII_DECIMAL_OP;
  localparam bac_op_e op_decin = BAC_ASCII_DECIMAL_TO_BINARY_OP;
  logic sys_clk, rst, op_req, cond_in, err_clr, done, dst_wr, preset_wr, exec_error_flag, err_led;
  bac_op_e op_code;
  bac_src_kind_e src_kind, cnt_kind;
  bac_dst_kind_e dst_kind;
  logic [15:0] src_data, src_tc_current, cnt_data, cnt_tc_current, dst_data, prev_dst;
  bac_chars_t src_chars, char_data, prev_chars;
  logic [4:0] char_wr;
  int mismatches, samples_checked;

  bac_converter uut (
    .sys_clk(sys_clk), .rst(rst), .op_req(op_req), .op_code(op_code), .cond_in(cond_in),
    .src_kind(src_kind), .src_data(src_data), .src_tc_current(src_tc_current), .src_chars(src_chars),
    .cnt_kind(cnt_kind), .cnt_data(cnt_data), .cnt_tc_current(cnt_tc_current), .dst_kind(dst_kind),
    .done(done), .dst_wr(dst_wr), .preset_wr(preset_wr), .dst_data(dst_data), .char_wr(char_wr),
    .char_data(char_data), .err_clr(err_clr), .exec_error_flag(exec_error_flag), .err_led(err_led)
  );

  // 10 MHz scan clock
  initial begin
    sys_clk = 1'h0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  function automatic bac_chars_t asc(input string s);
    bac_chars_t c;
    c = '0;
    for (int j = 0; j < s.len(); j++) begin
      c[j] = {8'h00, s[j]};
    end
    return c;
  endfunction

  // one request; a timer operand gets a decoy on the plain word input so a wrong pick shows
  task automatic run(input bac_op_e op, input logic c, input bac_src_kind_e sk, input logic [15:0] sd,
                     input string s, input bac_src_kind_e ck, input logic [15:0] cd, input bac_dst_kind_e dk);
    @(posedge sys_clk);
    #1;
    prev_dst = dst_data;
    prev_chars = char_data;
    op_req = 1'h1;
    op_code = op;
    cond_in = c;
    src_kind = sk;
    src_data = (sk == st) ? ~sd : sd;
    src_tc_current = (sk == st) ? sd : ~sd;
    src_chars = asc(s);
    cnt_kind = ck;
    cnt_data = (ck == st) ? ~cd : cd;
    cnt_tc_current = (ck == st) ? cd : ~cd;
    dst_kind = dk;
    @(posedge sys_clk);
    #1;
    op_req = 1'h0;
    chk(done, 1'h1);
  endtask

  task automatic good_bin(input logic [15:0] exp, input logic pre);
    chk({dst_wr, preset_wr, char_wr, exec_error_flag}, {!pre, pre, 6'h00});
    chk(dst_data, exp);
  endtask

  task automatic good_chr(input int n, input string e);
    bac_chars_t x;
    x = asc(e);
    chk({dst_wr, preset_wr, char_wr, exec_error_flag}, {2'h0, 5'((1 << n) - 1), 1'h0});
    for (int j = 0; j < n; j++) begin
      chk(char_data[j], x[j]);
    end
  endtask

  // refused request: nothing written, old results kept, flag and lamp up, then cleared
  task automatic bad();
    chk({dst_wr, preset_wr, char_wr}, 7'h00);
    chk(dst_data, prev_dst);
    chk(char_data, prev_chars);
    chk({exec_error_flag, err_led}, 2'h3);
    @(posedge sys_clk);
    #1;
    err_clr = 1'h1;
    @(posedge sys_clk);
    #1;
    err_clr = 1'h0;
    chk({exec_error_flag, err_led}, 2'h0);
  endtask

  task automatic t_bcd();
    run(op_bcd, 1'h1, sw, 16'h9999, "", sw, 16'h0000, dw);
    good_bin(16'h270f, 1'h0);
    run(op_bcd, 1'h1, st, 16'h0042, "", sw, 16'h0000, dt);
    good_bin(16'h002a, 1'h1);
    run(op_bcd, 1'h1, sb, 16'h0010, "", sw, 16'h0000, db);
    good_bin(16'h000a, 1'h0);
    run(op_bcd, 1'h1, sw, 16'h12a4, "", sw, 16'h0000, dw);
    bad();
    run(op_bcd, 1'h1, sw, 16'h0005, "", sw, 16'h0000, dsp);
    bad();
    run(op_tobcd, 1'h1, sw, 16'h270f, "", sw, 16'h0000, dw);
    good_bin(16'h9999, 1'h0);
    run(op_tobcd, 1'h1, sw, 16'h2710, "", sw, 16'h0000, dw);
    bad();
  endtask

  task automatic t_hex();
    run(op_hex, 1'h1, sw, 16'h1234, "", sw, 16'h0002, dw);
    good_chr(2, "34");
    run(op_hex, 1'h1, st, 16'habcd, "", st, 16'h0004, dw);
    good_chr(4, "ABCD");
    run(op_hex, 1'h1, sw, 16'h1234, "", sw, 16'h0001, dw);
    good_chr(1, "4");
    run(op_hex, 1'h1, sw, 16'h00ba, "", sw, 16'h0001, dw);
    good_chr(1, "A");
    run(op_hex, 1'h1, sw, 16'h1234, "", sw, 16'h0000, dw);
    bad();
    run(op_hex, 1'h1, sw, 16'h1234, "", sw, 16'h0005, dw);
    bad();
    run(op_hexin, 1'h1, sw, 16'h0000, "1A2F", st, 16'h0004, dt);
    good_bin(16'h1a2f, 1'h1);
    run(op_hexin, 1'h1, sw, 16'h0000, "F0zz", sw, 16'h0002, dw);
    good_bin(16'h00f0, 1'h0);
    run(op_hexin, 1'h1, sw, 16'h0000, "1a", sw, 16'h0002, dw);
    bad();
    run(op_hexin, 1'h1, sw, 16'h0000, "1G", sw, 16'h0002, dw);
    bad();
    run(op_hexin, 1'h1, sw, 16'h0000, "12345", sw, 16'h0005, dw);
    bad();
  endtask

  task automatic t_dec();
    run(op_dec, 1'h1, st, 16'hffff, "", sw, 16'h0005, dw);
    good_chr(5, "65535");
    run(op_dec, 1'h1, sw, 16'h038b, "", sw, 16'h0003, dw);
    good_chr(3, "907");
    run(op_dec, 1'h1, sw, 16'h0001, "", sw, 16'h0006, dw);
    bad();
    run(op_decin, 1'h1, sw, 16'h0000, "65535", sw, 16'h0005, dw);
    good_bin(16'hffff, 1'h0);
    run(op_decin, 1'h1, sw, 16'h0000, "42Zq", sw, 16'h0002, dt);
    good_bin(16'h002a, 1'h1);
    run(op_decin, 1'h1, sw, 16'h0000, "65536", sw, 16'h0005, dw);
    bad();
    run(op_decin, 1'h1, sw, 16'h0000, "1A", sw, 16'h0002, dw);
    bad();
    run(op_decin, 1'h1, sw, 16'h0000, "1", sw, 16'h0000, dw);
    bad();
  endtask

  // condition low does nothing; condition high repeats; a clear loses to a new error
  task automatic t_scan();
    run(op_bcd, 1'h0, sw, 16'h12a4, "", sw, 16'h0000, dw);
    chk({dst_wr, preset_wr, char_wr, exec_error_flag}, 8'h00);
    repeat (2) begin
      run(op_bcd, 1'h1, sw, 16'h0077, "", sw, 16'h0000, dw);
      good_bin(16'h004d, 1'h0);
    end
    run(bac_op_e'(3'h6), 1'h1, sw, 16'h0001, "", sw, 16'h0001, dw);
    bad();
    err_clr = 1'h1;
    run(op_hex, 1'h1, sw, 16'h0001, "", sw, 16'h0007, dw);
    err_clr = 1'h0;
    bad();
  endtask

  task automatic summarize();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // watchdog well past the hundred or so cycles the run needs
  initial begin
    #(1000 * 100);
    mismatches++;
    summarize();
  end

  initial begin
    {rst, op_req, cond_in, err_clr} = 4'h8;
    {op_code, src_kind, cnt_kind, dst_kind} = '0;
    {src_data, src_tc_current, cnt_data, cnt_tc_current} = '0;
    src_chars = '0;
    repeat (10) @(posedge sys_clk);
    #1;
    rst = 1'h0;
    t_bcd();
    t_hex();
    t_dec();
    t_scan();
    summarize();
  end
endmodule // bac_converter_tb
